// *** hdl/tsd_pkg.sv ***
// constants and carrier types for the timeslot demultiplexing sink
// Notes on behaviour
// RL1 - slip whole frames to adapt line to group clock
// RL2 - absorb line jitter and wander without slips
// RL3 - inactive slip stage sends all ones, reports nothing
// RL4 - trail fail forces all ones, restores promptly
// RL5 - count every controlled frame slip
// RL6 - account slips per one-second tick
// RL7 - plain demux extracts one timeslot 1 to 31
// RL8 - signalling demux extracts timeslot as LAPD channel
// RL9 - demux reads group only while activated
// RL10 - subset of instances, shared timeslots allowed
// RL11 - management deactivates mismatched sink instances
// RL12 - timeslots numbered 0 to 31 per frame
// RL13 - forward trail fail as server fail, pass data
// RL14 - demux server fail follows group fail input
package tsd_pkg;
   localparam int unsigned SLOTS_PER_FRAME = 32;
   localparam int unsigned SLOT_W = 5;
   localparam int unsigned OCTET_W = 8;
   localparam int unsigned FRAME_BUF_N = 4;
   localparam int unsigned FRAME_IDX_W = 2;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned FIFO_W = 1 + SLOT_W + OCTET_W;
   localparam int unsigned SLIP_CNT_W = 16;
   localparam int unsigned DONE_CNT_W = 3;
   localparam int unsigned FIRST_SLOT = 1;
   localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h1F;
   localparam logic [SLOT_W-1:0] FRAMING_SLOT = 5'h00;
   localparam logic [OCTET_W-1:0] ALL_ONES = 8'hFF;
   localparam logic [OCTET_W-1:0] LAPD_FLAG = 8'h7E;
   localparam logic [DONE_CNT_W-1:0] ONE_FRAME_DONE = 3'h1;
   localparam logic [DONE_CNT_W-1:0] DONE_CNT_MAX = 3'h7;
   // group bit period in local clock cycles, 10 MHz / 5 = 2 MHz bit rate
   localparam int unsigned GRP_BIT_DIV = 5;

   typedef struct packed {
      logic sof;
      logic [SLOT_W-1:0] slot;
      logic [OCTET_W-1:0] octet;
   } tsd_word_t;

   typedef struct packed {
      logic [OCTET_W-1:0] data;
      logic [SLOT_W-1:0] slot;
      logic stb;
      logic fs;
      logic fail;
   } tsd_grp_t;

   typedef struct packed {
      logic [OCTET_W-1:0] data;
      logic stb;
      logic fs;
      logic ssf;
   } tsd_chan_t;
endpackage

// *** hdl/tsd_sink.sv ***
// slip buffer, termination and per-timeslot demultiplexers of the sink
`timescale 1ns/100ps

// generic fifo with valid and ready on both sides
module tsd_fifo #(
   parameter int unsigned W = 14,
   parameter int unsigned D = 32
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   // full and empty from occupancy
   assign in_ready_o = (cnt_q != (AW+1)'(D));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem[rp_q];

   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_q] <= in_data_i;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
         if (pop) rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
         if (push && !pop) cnt_q <= cnt_q + (AW+1)'(1);
         else if (pop && !push) cnt_q <= cnt_q - (AW+1)'(1);
      end
   end
endmodule // tsd_fifo

// one timeslot demultiplexer, plain or signalling
module tsd_demux #(
   parameter bit LAPD = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire tsd_pkg::tsd_grp_t grp_i,
   input wire logic [tsd_pkg::SLOT_W-1:0] timeslot_i,
   input wire logic activate_in_i,
   input wire logic alarm_report_enable_i,
   output tsd_pkg::tsd_chan_t chan_o,
   output logic lapd_flag_o,
   output logic alarm_report_o
);
   tsd_pkg::tsd_chan_t chan_q;
   logic flag_q;
   logic rep_q;
   // slot 0 carries framing, so it selects nothing
   wire slot_ok = (timeslot_i != tsd_pkg::FRAMING_SLOT); // RL12
   wire hit = activate_in_i && slot_ok && grp_i.stb && (grp_i.slot == timeslot_i); // RL7 RL9 RL10
   wire [tsd_pkg::OCTET_W-1:0] octet = grp_i.fail ? tsd_pkg::ALL_ONES : grp_i.data; // RL4

   assign chan_o = chan_q;
   assign lapd_flag_o = flag_q;
   assign alarm_report_o = rep_q;

   // capture selected octet, pulse channel clock and frame start
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_q <= '{data: tsd_pkg::ALL_ONES, stb: 1'b0, fs: 1'b0, ssf: 1'b0};
         flag_q <= 1'b0;
         rep_q <= 1'b0;
      end else begin
         chan_q.stb <= hit; // RL7
         chan_q.fs <= hit;
         chan_q.ssf <= activate_in_i && grp_i.fail; // RL14
         rep_q <= LAPD && activate_in_i && grp_i.fail && alarm_report_enable_i;
         if (hit) begin
            chan_q.data <= octet;
            flag_q <= LAPD && (octet == tsd_pkg::LAPD_FLAG); // RL8
         end else if (!activate_in_i) begin
            chan_q.data <= tsd_pkg::ALL_ONES; // RL9
            flag_q <= 1'b0;
         end
      end
   end
endmodule // tsd_demux

// compound sink: line capture, slip buffer, termination, demux bank
module tsd_sink #(
   parameter int unsigned N_PLAIN = 4,
   parameter int unsigned N_LAPD = 2,
   parameter int unsigned BIT_DIV = tsd_pkg::GRP_BIT_DIV
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic line_clk_i,
   input wire logic line_data_i,
   input wire logic line_fs_i,
   input wire logic trail_fail_in_i,
   input wire logic activate_in_i,
   input wire logic one_second_tick_i,
   input wire logic [N_PLAIN*tsd_pkg::SLOT_W-1:0] plain_slot_i,
   input wire logic [N_PLAIN-1:0] plain_active_i,
   input wire logic [N_LAPD*tsd_pkg::SLOT_W-1:0] lapd_slot_i,
   input wire logic [N_LAPD-1:0] lapd_active_i,
   input wire logic [N_LAPD-1:0] alarm_report_enable_i,
   output tsd_pkg::tsd_grp_t group_o,
   output logic server_fail_out_o,
   output logic [tsd_pkg::SLIP_CNT_W-1:0] near_end_slip_count_o,
   output logic [tsd_pkg::SLIP_CNT_W-1:0] slips_last_second_o,
   output logic line_overflow_o,
   output tsd_pkg::tsd_chan_t [N_PLAIN-1:0] plain_chan_o,
   output tsd_pkg::tsd_chan_t [N_LAPD-1:0] lapd_chan_o,
   output logic [N_LAPD-1:0] lapd_flag_o,
   output logic [N_LAPD-1:0] lapd_alarm_report_o
);
   localparam int unsigned DW = $clog2(BIT_DIV);
   localparam int unsigned MW = tsd_pkg::FRAME_IDX_W + tsd_pkg::SLOT_W;

   // two-stage synchronisers for line pins and fail input
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic lclk_prev_q;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         lclk_prev_q <= 1'b0;
      end else begin
         sync1_q <= {trail_fail_in_i, line_fs_i, line_data_i, line_clk_i};
         sync2_q <= sync1_q;
         lclk_prev_q <= sync2_q[0];
      end
   end
   wire lclk_rise = sync2_q[0] && !lclk_prev_q;
   wire ldata = sync2_q[1];
   wire lfs = sync2_q[2];
   wire tfail = sync2_q[3];

   // line side octet assembly, frame start realigns bit and slot counts
   logic [2:0] lbit_q;
   logic [tsd_pkg::SLOT_W-1:0] lslot_q;
   logic [tsd_pkg::OCTET_W-1:0] lsh_q;
   logic oct_vld_q;
   tsd_pkg::tsd_word_t oct_q;
   logic fifo_in_ready;
   wire [2:0] bit_now = lfs ? 3'h0 : lbit_q;
   wire [tsd_pkg::SLOT_W-1:0] slot_now = lfs ? tsd_pkg::FRAMING_SLOT : lslot_q;
   wire [tsd_pkg::OCTET_W-1:0] sh_next = {lsh_q[6:0], ldata};
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lbit_q <= '0;
         lslot_q <= '0;
         lsh_q <= '0;
         oct_vld_q <= 1'b0;
         oct_q <= '0;
      end else begin
         oct_vld_q <= 1'b0;
         if (lclk_rise) begin
            lsh_q <= sh_next;
            lbit_q <= bit_now + 3'h1;
            if (bit_now == 3'h7) begin
               oct_vld_q <= 1'b1;
               oct_q <= '{sof: (slot_now == tsd_pkg::FRAMING_SLOT), slot: slot_now, octet: sh_next};
               lslot_q <= slot_now + tsd_pkg::SLOT_W'(1);
            end else begin
               lslot_q <= slot_now;
            end
         end
      end
   end

   // octet lost only when the fifo cannot take it
   logic ovf_q;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) ovf_q <= 1'b0;
      else ovf_q <= oct_vld_q && !fifo_in_ready;
   end
   assign line_overflow_o = ovf_q;

   // group timing: bit enable from divider, byte enable every eighth bit
   logic [DW-1:0] div_q;
   logic [2:0] gbit_q;
   wire bit_en = (div_q == DW'(BIT_DIV - 1));
   wire byte_en = bit_en && (gbit_q == 3'h7);
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_q <= '0;
         gbit_q <= '0;
      end else begin
         div_q <= bit_en ? '0 : div_q + DW'(1);
         if (bit_en) gbit_q <= gbit_q + 3'h1;
      end
   end

   // fifo drains into the frame store, stalled on group read cycles
   tsd_pkg::tsd_word_t fifo_out;
   logic fifo_out_valid;
   wire fifo_out_ready = !byte_en;
   tsd_fifo #(.W(tsd_pkg::FIFO_W), .D(tsd_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(oct_vld_q),
      .in_ready_o(fifo_in_ready),
      .in_data_i(oct_q),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out)
   );

   // frame store of four frames keeps reader well clear of writer
   logic [tsd_pkg::OCTET_W-1:0] fstore [tsd_pkg::FRAME_BUF_N*tsd_pkg::SLOTS_PER_FRAME]; // RL2
   logic [tsd_pkg::FRAME_IDX_W-1:0] wr_frame_q;
   logic [tsd_pkg::FRAME_IDX_W-1:0] rd_frame_q;
   logic [tsd_pkg::SLOT_W-1:0] rd_slot_q;
   logic [tsd_pkg::DONE_CNT_W-1:0] done_q;
   logic primed_q;
   wire store_wr = fifo_out_valid && fifo_out_ready;
   wire frame_done = store_wr && (fifo_out.slot == tsd_pkg::LAST_SLOT);
   wire pick = byte_en && (rd_slot_q == tsd_pkg::LAST_SLOT);
   wire [tsd_pkg::SLOT_W-1:0] rd_slot_next = rd_slot_q + tsd_pkg::SLOT_W'(1);
   wire [tsd_pkg::FRAME_IDX_W-1:0] last_done = wr_frame_q - tsd_pkg::FRAME_IDX_W'(1);
   wire [tsd_pkg::FRAME_IDX_W-1:0] frame_sel = pick ? last_done : rd_frame_q;
   wire [MW-1:0] rd_addr = {frame_sel, rd_slot_next};
   wire [MW-1:0] wr_addr = {wr_frame_q, fifo_out.slot};
   // none or several frames written since last pick means a slip
   wire slip_evt = pick && primed_q && (done_q != tsd_pkg::ONE_FRAME_DONE); // RL1
   wire [tsd_pkg::DONE_CNT_W-1:0] done_inc = (done_q == tsd_pkg::DONE_CNT_MAX) ? done_q
                                              : done_q + tsd_pkg::DONE_CNT_W'(1);

   always_ff @(posedge clk_i) begin
      if (store_wr) begin
         fstore[wr_addr] <= fifo_out.octet;
      end
   end

   // writer and reader frame tracking
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_frame_q <= '0;
         rd_frame_q <= '0;
         rd_slot_q <= '0;
         done_q <= '0;
         primed_q <= 1'b0;
      end else begin
         if (frame_done) wr_frame_q <= wr_frame_q + tsd_pkg::FRAME_IDX_W'(1);
         if (frame_done) primed_q <= 1'b1;
         if (byte_en) rd_slot_q <= rd_slot_next;
         if (pick) begin
            rd_frame_q <= last_done; // RL1
            done_q <= frame_done ? tsd_pkg::ONE_FRAME_DONE : '0;
         end else if (frame_done) begin
            done_q <= done_inc;
         end
      end
   end

   // group output with all-ones insertion when failed or inactive
   tsd_pkg::tsd_grp_t grp_q;
   logic ssf_q;
   wire ais = tfail || !activate_in_i || !primed_q; // RL3 RL4
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         grp_q <= '{data: tsd_pkg::ALL_ONES, slot: '0, stb: 1'b0, fs: 1'b0, fail: 1'b0};
         ssf_q <= 1'b0;
      end else begin
         ssf_q <= tfail; // RL13
         grp_q.stb <= byte_en;
         grp_q.fs <= byte_en && (rd_slot_next == tsd_pkg::FRAMING_SLOT);
         grp_q.fail <= tfail; // RL13
         if (byte_en) begin
            grp_q.slot <= rd_slot_next;
            grp_q.data <= ais ? tsd_pkg::ALL_ONES : fstore[rd_addr]; // RL3 RL4
         end
      end
   end
   // termination stage passes group signal and fail unchanged
   assign group_o = grp_q; // RL13
   assign server_fail_out_o = ssf_q;

   // slip counting, frozen and hidden while inactive
   logic [tsd_pkg::SLIP_CNT_W-1:0] slip_tot_q;
   logic [tsd_pkg::SLIP_CNT_W-1:0] slip_sec_q;
   logic [tsd_pkg::SLIP_CNT_W-1:0] slip_last_q;
   logic [tsd_pkg::SLIP_CNT_W-1:0] tot_out_q;
   wire count_slip = slip_evt && activate_in_i; // RL5
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slip_tot_q <= '0;
         slip_sec_q <= '0;
         slip_last_q <= '0;
         tot_out_q <= '0;
      end else begin
         if (count_slip) slip_tot_q <= slip_tot_q + tsd_pkg::SLIP_CNT_W'(1); // RL5
         // second boundary: latch and restart, a slip on the tick opens the new second
         if (one_second_tick_i) begin
            slip_last_q <= slip_sec_q; // RL6
            slip_sec_q <= count_slip ? tsd_pkg::SLIP_CNT_W'(1) : '0;
         end else if (count_slip) begin
            slip_sec_q <= slip_sec_q + tsd_pkg::SLIP_CNT_W'(1); // RL6
         end
         tot_out_q <= activate_in_i ? slip_tot_q : '0; // RL3
      end
   end
   assign near_end_slip_count_o = tot_out_q;
   assign slips_last_second_o = activate_in_i ? slip_last_q : '0; // RL3

   // demultiplexer bank, each instance with its own slot and activation
   genvar gi;
   generate
      for (gi = 0; gi < N_PLAIN; gi++) begin : g_plain
         tsd_demux #(.LAPD(1'b0)) u_dmx (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .grp_i(grp_q),
            .timeslot_i(plain_slot_i[gi*tsd_pkg::SLOT_W +: tsd_pkg::SLOT_W]),
            .activate_in_i(plain_active_i[gi]),
            .alarm_report_enable_i(1'b0),
            .chan_o(plain_chan_o[gi]),
            .lapd_flag_o(),
            .alarm_report_o()
         );
      end
      for (gi = 0; gi < N_LAPD; gi++) begin : g_lapd
         tsd_demux #(.LAPD(1'b1)) u_dmx (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .grp_i(grp_q),
            .timeslot_i(lapd_slot_i[gi*tsd_pkg::SLOT_W +: tsd_pkg::SLOT_W]),
            .activate_in_i(lapd_active_i[gi]),
            .alarm_report_enable_i(alarm_report_enable_i[gi]),
            .chan_o(lapd_chan_o[gi]),
            .lapd_flag_o(lapd_flag_o[gi]),
            .alarm_report_o(lapd_alarm_report_o[gi])
         );
      end
   endgenerate
endmodule // tsd_sink

// *** tb/tsd_line_src.sv ***
// framed line source standing in for the upstream path termination
`timescale 1ns/100ps
module tsd_line_src #(
   parameter logic [4:0] FLAG_SLOT = 5'h0A
) (
   output logic line_clk_o,
   output logic line_data_o,
   output logic line_fs_o,
   output int frames_o
);
   logic [7:0] oct;

   // free-running 800 ns line, msb first, slots 0 to 31 per frame
   initial begin
      line_clk_o = 1'b0;
      line_data_o = 1'b0;
      line_fs_o = 1'b0;
      frames_o = 0;
      forever for (int s = 0; s < 32; s++) for (int b = 7; b >= 0; b--) begin
         oct = (s[4:0] == FLAG_SLOT) ? 8'h7E : {3'h5, s[4:0]};
         line_data_o = oct[b];
         line_fs_o = (s == 0 && b == 7);
         #400 line_clk_o = 1'b1;
         #400 line_clk_o = 1'b0;
         if (s == 31 && b == 0) frames_o++;
      end
   end
endmodule // tsd_line_src

// *** tb/tsd_sink_bench.sv ***
// self-checking bench for the timeslot demultiplexing sink
`timescale 1ns/100ps
module tsd_sink_bench;
   localparam logic [4:0] FLAG_SLOT = 5'h0A;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic trail_fail_in_i = 1'b0;
   logic activate_in_i = 1'b0;
   logic one_second_tick_i = 1'b0;
   logic [19:0] plain_slot_i = 20'h00000;
   logic [3:0] plain_active_i = 4'h0;
   logic [9:0] lapd_slot_i = 10'h000;
   logic [1:0] lapd_active_i = 2'h0;
   logic [1:0] alarm_report_enable_i = 2'h0;
   logic line_clk_i, line_data_i, line_fs_i, server_fail_out_o, line_overflow_o;
   tsd_pkg::tsd_grp_t group_o;
   logic [15:0] near_end_slip_count_o, slips_last_second_o;
   tsd_pkg::tsd_chan_t [3:0] plain_chan_o;
   tsd_pkg::tsd_chan_t [1:0] lapd_chan_o;
   logic [1:0] lapd_flag_o, lapd_alarm_report_o;
   int error_cnt = 0;
   int num_checks = 0;
   int frames;

   always #50 clk_i = ~clk_i;

   tsd_line_src #(.FLAG_SLOT(FLAG_SLOT)) u_line (.line_clk_o(line_clk_i), .line_data_o(line_data_i),
      .line_fs_o(line_fs_i), .frames_o(frames));
   tsd_sink DUT (.clk_i, .rst_b_i, .line_clk_i, .line_data_i, .line_fs_i, .trail_fail_in_i, .activate_in_i,
      .one_second_tick_i, .plain_slot_i, .plain_active_i, .lapd_slot_i, .lapd_active_i, .alarm_report_enable_i,
      .group_o, .server_fail_out_o, .near_end_slip_count_o, .slips_last_second_o, .line_overflow_o,
      .plain_chan_o, .lapd_chan_o, .lapd_flag_o, .lapd_alarm_report_o);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         error_cnt++;
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // strobe of plain 0..3, signalling 4..5, group 6
   function automatic logic stb_of(input int k);
      if (k < 4) return plain_chan_o[k].stb;
      if (k < 6) return lapd_chan_o[k-4].stb;
      return group_o.stb;
   endfunction

   task automatic wait_stb(input int k, input int lim);
      int n;
      n = 0;
      while (stb_of(k) !== 1'b1 && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (stb_of(k) !== 1'b1) begin
         $display("mismatch at %0t: seen %h expected %h", $time, stb_of(k), 1'b1);
         error_cnt++;
         stop_test();
      end
   endtask

   task automatic count_stb(input int k, input int cyc, output int cnt);
      cnt = 0;
      repeat (cyc) begin
         @(negedge clk_i);
         if (stb_of(k) === 1'b1) cnt++;
      end
   endtask

   task automatic tick();
      @(posedge clk_i);
      one_second_tick_i <= 1'b1;
      @(posedge clk_i);
      one_second_tick_i <= 1'b0;
   endtask

   // inactive slip stage: all ones, no counts
   task automatic t_inactive();
      @(posedge clk_i);
      activate_in_i <= 1'b0;
      repeat (3000) @(negedge clk_i);
      wait_stb(6, 100);
      check(group_o.data, 8'hFF);
      check(near_end_slip_count_o, 16'h0000);
      check(slips_last_second_o, 16'h0000);
      $display("test inactive done");
   endtask

   // extraction, shared slots and signalling channels
   task automatic t_extract();
      @(posedge clk_i);
      activate_in_i <= 1'b1;
      plain_slot_i <= {5'h00, 5'h1F, 5'h1F, 5'h01};
      plain_active_i <= 4'hF;
      lapd_slot_i <= {5'h05, FLAG_SLOT};
      lapd_active_i <= 2'h3;
      alarm_report_enable_i <= 2'h1;
      repeat (6200) @(negedge clk_i);
      wait_stb(0, 1400);
      check(plain_chan_o[0].data, 8'hA1);
      check(plain_chan_o[0].fs, 1'b1);
      wait_stb(1, 1400);
      check(plain_chan_o[2].stb, 1'b1);
      check(plain_chan_o[2].data, 8'hBF);
      wait_stb(4, 1400);
      check(lapd_chan_o[0].data, 8'h7E);
      repeat (2) @(negedge clk_i);
      check(lapd_flag_o[0], 1'b1);
      wait_stb(5, 1400);
      check(lapd_chan_o[1].data, 8'hA5);
      $display("test extract done");
   endtask

   // deactivated and idle instances stay silent
   task automatic t_demux_off();
      int n;
      @(posedge clk_i);
      plain_active_i <= 4'hE;
      @(posedge clk_i);
      count_stb(0, 2600, n);
      check(16'(n), 16'h0000);
      check(plain_chan_o[0].data, 8'hFF);
      count_stb(3, 1300, n);
      check(16'(n), 16'h0000);
      @(posedge clk_i);
      plain_active_i <= 4'hF;
      $display("test demux off done");
   endtask

   // trail fail forces all ones and server fail, then clears
   task automatic t_fail();
      @(posedge clk_i);
      trail_fail_in_i <= 1'b1;
      repeat (50) @(negedge clk_i);
      check(server_fail_out_o, 1'b1);
      wait_stb(0, 1400);
      check(plain_chan_o[0].data, 8'hFF);
      check(plain_chan_o[0].ssf, 1'b1);
      check(lapd_alarm_report_o, 2'h1);
      @(posedge clk_i);
      trail_fail_in_i <= 1'b0;
      repeat (50) @(negedge clk_i);
      check(server_fail_out_o, 1'b0);
      wait_stb(0, 1400);
      check(plain_chan_o[0].data, 8'hA1);
      check(plain_chan_o[0].ssf, 1'b0);
      $display("test fail done");
   endtask

   // slower line forces repeats, counted per second
   task automatic t_slips();
      int g, f0, d, ov;
      logic [15:0] n0;
      g = 0;
      ov = 0;
      tick();
      @(negedge clk_i);
      f0 = frames;
      n0 = near_end_slip_count_o;
      repeat (7680) begin
         @(negedge clk_i);
         if (group_o.fs === 1'b1) g++;
         if (line_overflow_o === 1'b1) ov++;
      end
      tick();
      @(negedge clk_i);
      check(16'(ov), 16'h0000);
      d = int'(slips_last_second_o) - g + (frames - f0);
      check(16'(d >= -2 && d <= 2), 16'h0001);
      check(16'(slips_last_second_o != 16'h0000), 16'h0001);
      check(near_end_slip_count_o - n0, slips_last_second_o);
      $display("test slips done");
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_inactive();
      t_extract();
      t_demux_off();
      t_fail();
      t_slips();
      t_inactive();
      stop_test();
   end
endmodule // tsd_sink_bench

bind tsd_sink tsd_sink_monitor #(.N_PLAIN(N_PLAIN), .N_LAPD(N_LAPD), .BIT_DIV(BIT_DIV)) u_mon (.clk_i, .rst_b_i,
   .trail_fail_in_i, .activate_in_i, .plain_slot_i, .plain_active_i, .group_o, .server_fail_out_o,
   .near_end_slip_count_o, .slips_last_second_o, .plain_chan_o);

// *** tb/tsd_sink_monitor.sv ***
// port-level assertions for the timeslot demultiplexing sink
`timescale 1ns/100ps
module tsd_sink_monitor #(
   parameter int unsigned N_PLAIN = 4,
   parameter int unsigned N_LAPD = 2,
   parameter int unsigned BIT_DIV = 5
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic trail_fail_in_i,
   input wire logic activate_in_i,
   input wire logic [N_PLAIN*tsd_pkg::SLOT_W-1:0] plain_slot_i,
   input wire logic [N_PLAIN-1:0] plain_active_i,
   input wire tsd_pkg::tsd_grp_t group_o,
   input wire logic server_fail_out_o,
   input wire logic [tsd_pkg::SLIP_CNT_W-1:0] near_end_slip_count_o,
   input wire logic [tsd_pkg::SLIP_CNT_W-1:0] slips_last_second_o,
   input wire tsd_pkg::tsd_chan_t [N_PLAIN-1:0] plain_chan_o
);
   int unsigned gap_q;
   logic seen_q;
   logic [4:0] slot_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // cycles since the last group strobe and the slot it carried
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap_q <= 0;
         seen_q <= 1'b0;
         slot_q <= 5'h00;
      end else if (group_o.stb) begin
         gap_q <= 0;
         seen_q <= 1'b1;
         slot_q <= group_o.slot;
      end else begin
         gap_q <= gap_q + 1;
      end
   end

   // group timing and slot order
   a_stb_spacing: assert property (group_o.stb && seen_q |-> gap_q == BIT_DIV * 8 - 1)
      else $error("group strobe spacing wrong");
   a_slot_order: assert property (group_o.stb && seen_q |-> group_o.slot == slot_q + 5'h01)
      else $error("group slot did not advance by one");
   a_fs_slot_zero: assert property (group_o.fs |-> group_o.stb && group_o.slot == 5'h00)
      else $error("frame start off slot zero");
   // fail, inactive and slip count handling
   a_fail_all_ones: assert property (group_o.stb && group_o.fail |-> group_o.data == 8'hFF)
      else $error("failed group octet not all ones");
   a_ssf_follow: assert property ($rose(trail_fail_in_i) |-> ##[1:4] server_fail_out_o)
      else $error("server fail not forwarded");
   a_idle_ones: assert property ((!activate_in_i)[*4] ##0 group_o.stb |-> group_o.data == 8'hFF)
      else $error("inactive stage not sending all ones");
   a_idle_counts: assert property ((!activate_in_i)[*3] |-> near_end_slip_count_o == 16'h0000 && slips_last_second_o == 16'h0000)
      else $error("inactive stage reports slips");
   a_slip_step: assert property (activate_in_i[*3] |-> (near_end_slip_count_o == $past(near_end_slip_count_o)) || (near_end_slip_count_o == $past(near_end_slip_count_o) + 16'h0001))
      else $error("slip count jumped");
   // demux instance 0
   a_chan_hit: assert property (group_o.stb && plain_active_i[0] && plain_slot_i[4:0] != 5'h00 && group_o.slot == plain_slot_i[4:0] |=> plain_chan_o[0].stb && plain_chan_o[0].data == $past(group_o.data))
      else $error("channel missed its slot");
   a_chan_only: assert property (plain_chan_o[0].stb |-> $past(group_o.stb) && $past(plain_active_i[0]) && $past(group_o.slot) == $past(plain_slot_i[4:0]))
      else $error("channel strobe without matching slot");
   a_chan_ssf: assert property ((plain_active_i[0] && group_o.fail)[*2] |-> plain_chan_o[0].ssf)
      else $error("channel server fail missing");
endmodule // tsd_sink_monitor
